/* rtl/bec_pkg.sv */
// Constants for the burst error-correcting check block
package bec_pkg;
    // ============================================================
    // Code geometry
    localparam int unsigned WORDS_PER_FIELD = 256;
    localparam int unsigned CHK_BITS        = 32;
    localparam int unsigned BURST_BITS      = 11;
    localparam int unsigned WBITS_16        = 16;
    localparam int unsigned WBITS_18        = 18;
    // Steps until a burst starting on the check field's first bit sits at syndrome bit 10
    localparam int unsigned ISO_LAG         = 2 * CHK_BITS - BURST_BITS;
    // Fire code (x^21+1)(x^11+x^2+1), the x^32 term implied
    localparam logic [31:0] GEN_POLY        = 32'h00A00805;

    // ============================================================
    // Register byte offsets
    localparam logic [7:0] OFS_OFFSET   = 8'h00;
    localparam logic [7:0] OFS_ERR1     = 8'h04;
    localparam logic [7:0] OFS_POSITION = 8'h08;
    localparam logic [7:0] OFS_PATTERN  = 8'h0C;
    localparam logic [7:0] OFS_STATUS   = 8'h10;
    localparam logic [7:0] OFS_INT_STAT = 8'h14;
    localparam logic [7:0] OFS_INT_CLR  = 8'h18;
    localparam logic [7:0] OFS_INT_EN   = 8'h1C;

    // ============================================================
    // Field positions
    localparam int unsigned OF_DIR_BIT  = 7;
    localparam int unsigned OF_HCI_BIT  = 10;
    localparam int unsigned OF_ECI_BIT  = 11;
    localparam int unsigned OF_FMT_BIT  = 12;
    localparam int unsigned ER1_ECH_BIT = 6;
    localparam int unsigned ER1_DCK_BIT = 15;
    localparam int unsigned POS_BITS    = 13;
    localparam int unsigned INT_WR_DONE = 0;
    localparam int unsigned INT_RD_DONE = 1;
    localparam int unsigned INT_DCK     = 2;
    localparam int unsigned INT_ECH     = 3;
    localparam int unsigned INT_BITS    = 4;

    // ============================================================
    // Reset values
    localparam logic [15:0] OFFSET_RST  = 16'h0000;
    localparam logic [3:0]  INT_EN_RST  = 4'h0;

    typedef enum {
        BEC_IDLE,
        BEC_WDATA,
        BEC_WCHK,
        BEC_RDATA,
        BEC_RCHK,
        BEC_ISO
    } bec_state_t;
endpackage

/* rtl/bec_core.sv */
// Burst ECC generator, checker and burst isolator with APB registers
// Behaviour
// - Code corrects any single error burst up to 11 contiguous bits.
// - Errors longer than the burst are detected and, with correction enabled, set the hard-error flag.
// - Burst pattern sits read-only in bits 0-10, upper bits read zero.
// - Position register holds bit address of burst's first bit in field.
// - Write check generation covers first bit after sync to last data bit.
// - After word 256 the 32-bit check field is shifted out unaltered.
// - Field is 256 words in 16- or 18-bit format, check field follows.
// - After 256 read words host is blocked until check field and any isolation pass.
// - Check processing stops at the last bit of the check field.
// - Nonzero remainder sets data-check flag, bit 15 of error register one.
// - Clean read ends immediately with no extra delay.
// - Detected error with correction enabled runs burst isolation.
// - Data-check flag stays set throughout isolation.
// - Correction inhibit is bit 11 of the offset register.
// - With inhibit set, isolation is skipped and read ends as if clean.
// - With inhibit clear, correction runs whenever an error is found.
//
// The address map and the APB slave port were chosen for this implementation.
module bec_core #(
    parameter int unsigned WORDS = bec_pkg::WORDS_PER_FIELD
) (
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    input  wire logic        wr_start,
    input  wire logic [17:0] wr_data,
    input  wire logic        wr_valid,
    output logic             wr_ready,
    output logic             disk_wr_bit,
    output logic             disk_wr_en,
    input  wire logic        rd_start,
    input  wire logic        disk_rd_bit,
    input  wire logic        disk_rd_valid,
    output logic [17:0]      rd_data,
    output logic             rd_valid,
    output logic             host_block,
    output logic             rd_done,
    output logic             wr_done
);
    if (WORDS < 2 || WORDS > 256) begin : g_bad_words
        $error("WORDS must lie in 2..256");
    end

    // ============================================================
    // Arithmetic helpers
    // Forward divider step, data premultiplied by x^32
    function automatic logic [31:0] div_step(input logic [31:0] r, input logic d);
        logic fb;
        fb = d ^ r[31];
        return {r[30:0], 1'b0} ^ (fb ? bec_pkg::GEN_POLY : 32'h00000000);
    endfunction

    // Multiply by x^-1 modulo the generator
    function automatic logic [31:0] back_step(input logic [31:0] s);
        return s[0] ? ({1'b0, s[31:1]} ^ {1'b1, bec_pkg::GEN_POLY[31:1]}) : {1'b0, s[31:1]};
    endfunction

    function automatic logic [10:0] rev11(input logic [10:0] v);
        logic [10:0] o;
        o = '0;
        for (int i = 0; i < 11; i++) begin
            o[i] = v[10 - i];
        end
        return o;
    endfunction

    // ============================================================
    // State
    bec_pkg::bec_state_t state_ff, nxt_state;
    logic [31:0] rem_ff, nxt_rem;
    logic [17:0] sh_ff, nxt_sh;
    logic [4:0]  bit_cnt_ff, nxt_bit_cnt;
    logic [8:0]  word_cnt_ff, nxt_word_cnt;
    logic [13:0] k_ff, nxt_k;
    logic        fmt18_ff, nxt_fmt18;
    logic [10:0] pat_ff, nxt_pat;
    logic [12:0] pos_ff, nxt_pos;
    logic        dck_ff, nxt_dck;
    logic        ech_ff, nxt_ech;
    logic [17:0] rd_data_ff, nxt_rd_data;
    logic        rd_valid_ff, nxt_rd_valid;
    logic        rd_done_ff, nxt_rd_done;
    logic        wr_done_ff, nxt_wr_done;
    logic        wbit_ff, nxt_wbit;
    logic        wen_ff, nxt_wen;
    logic [15:0] offset_ff, nxt_offset;
    logic [3:0]  int_stat_ff, nxt_int_stat;
    logic [3:0]  int_en_ff, nxt_int_en;
    logic [31:0] prdata_ff, nxt_prdata;
    logic        err_ff, nxt_err;

    logic [4:0]  wbits;
    logic [13:0] nbits;
    logic        correction_inhibit_bit;
    logic [31:0] rd_rem;
    logic        last_chk;
    logic [3:0]  events;

    assign correction_inhibit_bit    = offset_ff[bec_pkg::OF_ECI_BIT];
    assign wbits  = fmt18_ff ? 5'(bec_pkg::WBITS_18) : 5'(bec_pkg::WBITS_16);
    assign nbits  = 14'(WORDS) * 14'(wbits);
    assign rd_rem = div_step(rem_ff, disk_rd_bit);
    assign last_chk = (state_ff == bec_pkg::BEC_RCHK) && disk_rd_valid
                      && (bit_cnt_ff == 5'(bec_pkg::CHK_BITS - 1));

    // ============================================================
    // Transfer engine; at most one bit per clock, with one idle load clock per write word
    always_comb begin
        nxt_state    = state_ff;
        nxt_rem      = rem_ff;
        nxt_sh       = sh_ff;
        nxt_bit_cnt  = bit_cnt_ff;
        nxt_word_cnt = word_cnt_ff;
        nxt_k        = k_ff;
        nxt_fmt18    = fmt18_ff;
        nxt_pat      = pat_ff;
        nxt_pos      = pos_ff;
        nxt_dck      = dck_ff;
        nxt_ech      = ech_ff;
        nxt_rd_data  = rd_data_ff;
        nxt_rd_valid = 1'b0;
        nxt_rd_done  = 1'b0;
        nxt_wr_done  = 1'b0;
        nxt_wbit     = 1'b0;
        nxt_wen      = 1'b0;
        wr_ready     = 1'b0;
        case (state_ff)
            bec_pkg::BEC_IDLE: begin
                nxt_rem      = '0;
                nxt_bit_cnt  = '0;
                nxt_word_cnt = '0;
                nxt_fmt18    = ~offset_ff[bec_pkg::OF_FMT_BIT];
                if (wr_start) begin
                    nxt_state = bec_pkg::BEC_WDATA;
                end else if (rd_start) begin
                    nxt_state = bec_pkg::BEC_RDATA;
                    nxt_dck   = 1'b0;
                    nxt_ech   = 1'b0;
                end
            end
            bec_pkg::BEC_WDATA: begin
                // Gaps in the host stream simply pause the disk bit stream
                wr_ready = (bit_cnt_ff == 5'd0);
                if (bit_cnt_ff == 5'd0) begin
                    if (wr_valid) begin
                        nxt_sh      = fmt18_ff ? wr_data : {wr_data[15:0], 2'b00};
                        nxt_bit_cnt = wbits;
                    end
                end else begin
                    nxt_wbit    = sh_ff[17];
                    nxt_wen     = 1'b1;
                    nxt_rem     = div_step(rem_ff, sh_ff[17]);
                    nxt_sh      = {sh_ff[16:0], 1'b0};
                    nxt_bit_cnt = bit_cnt_ff - 5'd1;
                    if (bit_cnt_ff == 5'd1) begin
                        nxt_word_cnt = word_cnt_ff + 9'd1;
                        if (word_cnt_ff == 9'(WORDS - 1)) begin
                            nxt_state   = bec_pkg::BEC_WCHK;
                            nxt_bit_cnt = '0;
                        end
                    end
                end
            end
            bec_pkg::BEC_WCHK: begin
                // Remainder leaves MSB first with no feedback
                nxt_wbit    = rem_ff[31];
                nxt_wen     = 1'b1;
                nxt_rem     = {rem_ff[30:0], 1'b0};
                nxt_bit_cnt = bit_cnt_ff + 5'd1;
                if (bit_cnt_ff == 5'(bec_pkg::CHK_BITS - 1)) begin
                    nxt_state   = bec_pkg::BEC_IDLE;
                    nxt_wr_done = 1'b1;
                end
            end
            bec_pkg::BEC_RDATA: begin
                if (disk_rd_valid) begin
                    nxt_rem     = rd_rem;
                    nxt_sh      = {sh_ff[16:0], disk_rd_bit};
                    nxt_bit_cnt = bit_cnt_ff + 5'd1;
                    if (bit_cnt_ff == wbits - 5'd1) begin
                        nxt_bit_cnt  = '0;
                        nxt_rd_data  = fmt18_ff ? {sh_ff[16:0], disk_rd_bit} : {2'b00, sh_ff[14:0], disk_rd_bit};
                        nxt_rd_valid = 1'b1;
                        nxt_word_cnt = word_cnt_ff + 9'd1;
                        if (word_cnt_ff == 9'(WORDS - 1)) begin
                            nxt_state = bec_pkg::BEC_RCHK;
                        end
                    end
                end
            end
            bec_pkg::BEC_RCHK: begin
                if (disk_rd_valid) begin
                    nxt_rem     = rd_rem;
                    nxt_bit_cnt = bit_cnt_ff + 5'd1;
                end
                if (last_chk) begin
                    // Evaluated on the last bit itself so a clean read costs nothing
                    nxt_k = '0;
                    if (rd_rem == 32'h00000000) begin
                        nxt_state   = bec_pkg::BEC_IDLE;
                        nxt_rd_done = 1'b1;
                    end else begin
                        nxt_dck = 1'b1;
                        if (correction_inhibit_bit) begin
                            nxt_state   = bec_pkg::BEC_IDLE;
                            nxt_rd_done = 1'b1;
                        end else begin
                            nxt_state = bec_pkg::BEC_ISO;
                        end
                    end
                end
            end
            bec_pkg::BEC_ISO: begin
                // Burst trapped once the 21 high syndrome bits are clear
                if (rem_ff[31:11] == 21'h000000) begin
                    nxt_state   = bec_pkg::BEC_IDLE;
                    nxt_rd_done = 1'b1;
                    // A burst whose first bit lies in the check field needs no repair
                    if (k_ff <= 14'(bec_pkg::ISO_LAG)) begin
                        nxt_pat = '0;
                        nxt_pos = '0;
                    end else begin
                        nxt_pat = rev11(rem_ff[10:0]);
                        nxt_pos = 13'(nbits + 14'(bec_pkg::ISO_LAG) - k_ff);
                    end
                end else if (k_ff == nbits + 14'(bec_pkg::ISO_LAG)) begin
                    nxt_state   = bec_pkg::BEC_IDLE;
                    nxt_ech     = 1'b1;
                    nxt_rd_done = 1'b1;
                end else begin
                    nxt_rem = back_step(rem_ff);
                    nxt_k   = k_ff + 14'd1;
                end
            end
            default: begin
                nxt_state = bec_pkg::BEC_IDLE;
            end
        endcase
    end

    // Host blocked through check field and isolation
    assign host_block  = (state_ff == bec_pkg::BEC_RCHK) || (state_ff == bec_pkg::BEC_ISO);
    assign disk_wr_bit = wbit_ff;
    assign disk_wr_en  = wen_ff;
    assign rd_data     = rd_data_ff;
    assign rd_valid    = rd_valid_ff;
    assign rd_done     = rd_done_ff;
    assign wr_done     = wr_done_ff;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_ff    <= bec_pkg::BEC_IDLE;
            rem_ff      <= '0;
            sh_ff       <= '0;
            bit_cnt_ff  <= '0;
            word_cnt_ff <= '0;
            k_ff        <= '0;
            fmt18_ff    <= 1'b0;
            pat_ff      <= '0;
            pos_ff      <= '0;
            dck_ff      <= 1'b0;
            ech_ff      <= 1'b0;
            rd_data_ff  <= '0;
            rd_valid_ff <= 1'b0;
            rd_done_ff  <= 1'b0;
            wr_done_ff  <= 1'b0;
            wbit_ff     <= 1'b0;
            wen_ff      <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            rem_ff      <= nxt_rem;
            sh_ff       <= nxt_sh;
            bit_cnt_ff  <= nxt_bit_cnt;
            word_cnt_ff <= nxt_word_cnt;
            k_ff        <= nxt_k;
            fmt18_ff    <= nxt_fmt18;
            pat_ff      <= nxt_pat;
            pos_ff      <= nxt_pos;
            dck_ff      <= nxt_dck;
            ech_ff      <= nxt_ech;
            rd_data_ff  <= nxt_rd_data;
            rd_valid_ff <= nxt_rd_valid;
            rd_done_ff  <= nxt_rd_done;
            wr_done_ff  <= nxt_wr_done;
            wbit_ff     <= nxt_wbit;
            wen_ff      <= nxt_wen;
        end
    end

    // ============================================================
    // APB slave; read data registered in setup, so no wait state
    logic setup_ph;
    logic wr_acc;
    assign setup_ph = psel && !penable;
    assign wr_acc   = psel && penable && pwrite;
    assign events   = {nxt_ech & ~ech_ff, nxt_dck & ~dck_ff, nxt_rd_done, nxt_wr_done};

    always_comb begin
        nxt_offset   = offset_ff;
        nxt_int_en   = int_en_ff;
        nxt_int_stat = int_stat_ff;
        nxt_prdata   = prdata_ff;
        nxt_err      = err_ff;
        if (wr_acc && paddr == bec_pkg::OFS_OFFSET) begin
            nxt_offset = '0;
            nxt_offset[bec_pkg::OF_DIR_BIT] = pwdata[bec_pkg::OF_DIR_BIT];
            nxt_offset[bec_pkg::OF_HCI_BIT] = pwdata[bec_pkg::OF_HCI_BIT];
            nxt_offset[bec_pkg::OF_ECI_BIT] = pwdata[bec_pkg::OF_ECI_BIT];
            nxt_offset[bec_pkg::OF_FMT_BIT] = pwdata[bec_pkg::OF_FMT_BIT];
        end
        if (wr_acc && paddr == bec_pkg::OFS_INT_EN) begin
            nxt_int_en = pwdata[3:0];
        end
        if (wr_acc && paddr == bec_pkg::OFS_INT_CLR) begin
            nxt_int_stat = nxt_int_stat & ~pwdata[3:0];
        end
        // New events win over a clear in the same cycle
        nxt_int_stat = nxt_int_stat | events;
        if (setup_ph) begin
            nxt_prdata = '0;
            nxt_err    = 1'b0;
            case (paddr)
                bec_pkg::OFS_OFFSET:   nxt_prdata = {16'h0000, offset_ff};
                bec_pkg::OFS_ERR1: begin
                    nxt_prdata[bec_pkg::ER1_DCK_BIT] = dck_ff;
                    nxt_prdata[bec_pkg::ER1_ECH_BIT] = ech_ff;
                end
                bec_pkg::OFS_POSITION: nxt_prdata = {19'h00000, pos_ff};
                bec_pkg::OFS_PATTERN:  nxt_prdata = {21'h000000, pat_ff};
                bec_pkg::OFS_STATUS:   nxt_prdata = {30'h00000000, host_block, state_ff != bec_pkg::BEC_IDLE};
                bec_pkg::OFS_INT_STAT: nxt_prdata = {28'h0000000, int_stat_ff};
                bec_pkg::OFS_INT_CLR:  nxt_prdata = '0;
                bec_pkg::OFS_INT_EN:   nxt_prdata = {28'h0000000, int_en_ff};
                default:               nxt_err = 1'b1;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            offset_ff   <= bec_pkg::OFFSET_RST;
            int_en_ff   <= bec_pkg::INT_EN_RST;
            int_stat_ff <= '0;
            prdata_ff   <= '0;
            err_ff      <= 1'b0;
        end else begin
            offset_ff   <= nxt_offset;
            int_en_ff   <= nxt_int_en;
            int_stat_ff <= nxt_int_stat;
            prdata_ff   <= nxt_prdata;
            err_ff      <= nxt_err;
        end
    end

    assign pready  = psel && penable;
    assign pslverr = psel && penable && err_ff;
    assign prdata  = prdata_ff;
    assign irq     = |(int_stat_ff & int_en_ff);

    // ============================================================
    // Checks
    sequence seq_last_bit;
        last_chk;
    endsequence
    sequence seq_clean_last;
        last_chk && (rd_rem == 32'h00000000);
    endsequence
    sequence seq_dirty_last;
        last_chk && (rd_rem != 32'h00000000);
    endsequence

    chk_dck_on_error: assert property (@(posedge ref_clk) disable iff (srst)
        seq_dirty_last |=> dck_ff) else $error("data check flag not set on bad remainder");
    chk_clean_end: assert property (@(posedge ref_clk) disable iff (srst)
        seq_clean_last |=> rd_done && !dck_ff && (state_ff == bec_pkg::BEC_IDLE))
        else $error("clean read did not end at once");
    chk_check_stop: assert property (@(posedge ref_clk) disable iff (srst)
        seq_last_bit |=> !host_block || (state_ff == bec_pkg::BEC_ISO))
        else $error("check field processing ran past its last bit");
    chk_inhibit_skip: assert property (@(posedge ref_clk) disable iff (srst)
        seq_dirty_last and correction_inhibit_bit |=> (state_ff == bec_pkg::BEC_IDLE) && rd_done)
        else $error("isolation ran with inhibit set");
    chk_iso_start: assert property (@(posedge ref_clk) disable iff (srst)
        seq_dirty_last and !correction_inhibit_bit |=> (state_ff == bec_pkg::BEC_ISO))
        else $error("isolation not started with correction enabled");
    chk_iso_flag: assert property (@(posedge ref_clk) disable iff (srst)
        (state_ff == bec_pkg::BEC_ISO) |-> dck_ff && host_block) else $error("flag dropped during isolation");
    chk_block_quiet: assert property (@(posedge ref_clk) disable iff (srst)
        $rose(host_block) |-> ##1 !rd_valid [*8]) else $error("word delivered while host blocked");
    chk_iso_bound: assert property (@(posedge ref_clk) disable iff (srst)
        (state_ff == bec_pkg::BEC_ISO) |-> k_ff <= nbits + 14'(bec_pkg::ISO_LAG))
        else $error("isolation step count out of range");
    chk_wr_chk_len: assert property (@(posedge ref_clk) disable iff (srst)
        $rose(state_ff == bec_pkg::BEC_WCHK) |-> disk_wr_en [*8]) else $error("check field not shifted back to back");
    chk_pattern_top: assert property (@(posedge ref_clk) disable iff (srst)
        setup_ph && paddr == bec_pkg::OFS_PATTERN |=> prdata[31:11] == 21'h000000)
        else $error("pattern upper bits not zero");
endmodule

/* test/bec_disk_model.sv */
// Disk surface model: records one written field and replays it with errors
module bec_disk_model #(
    parameter int NB = 64
) (
    input  wire logic          ref_clk,
    input  wire logic          srst,
    input  wire logic          disk_wr_bit,
    input  wire logic          disk_wr_en,
    input  wire logic          play,
    input  wire logic [NB-1:0] err,
    output logic               disk_rd_bit,
    output logic               disk_rd_valid,
    output logic [NB-1:0]      surf,
    output int                 wr_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    int   rd_idx;
    logic last_bit;
    // ============================================================
    // Recording and replay, first stream bit kept at the top of surf
    always @(posedge ref_clk) begin
        last_bit <= disk_rd_bit;
        if (srst) begin
            wr_cnt <= 0;
            rd_idx <= NB;
        end else begin
            if (disk_wr_en) begin
                surf[NB-1-(wr_cnt % NB)] <= disk_wr_bit;
                wr_cnt <= wr_cnt + 1;
            end
            if (play) begin
                rd_idx <= 0;
            end else if (rd_idx < NB) begin
                rd_idx <= rd_idx + 1;
            end
        end
    end
    // Outside a frame the line flips, so a stale bit is never mistaken for data
    always_comb begin
        disk_rd_valid = (rd_idx < NB);
        disk_rd_bit   = disk_rd_valid ? surf[NB-1-rd_idx] ^ err[NB-1-rd_idx] : ~last_bit;
    end
endmodule

/* test/burst_ecc_correction_tb.sv */
// Testbench for the burst ECC block: APB registers, write field, read fields
module burst_ecc_correction_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WORDS = 2;
    logic ref_clk, srst, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic wr_start, wr_valid, wr_ready, dwb, dwe, rd_start, drb, drv;
    logic [17:0] wr_data, rd_data;
    logic rd_valid, host_block, rd_done, wr_done, play, e;
    logic [63:0] err, surf, s;
    int wr_cnt, miscompares, total_checks, c0, c1, c2;
    logic [17:0] rd_q[$];
    bec_core #(.WORDS(WORDS)) bec_core_i (.ref_clk(ref_clk), .srst(srst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .wr_start(wr_start), .wr_data(wr_data), .wr_valid(wr_valid),
        .wr_ready(wr_ready), .disk_wr_bit(dwb), .disk_wr_en(dwe), .rd_start(rd_start),
        .disk_rd_bit(drb), .disk_rd_valid(drv), .rd_data(rd_data), .rd_valid(rd_valid),
        .host_block(host_block), .rd_done(rd_done), .wr_done(wr_done));
    bec_disk_model #(.NB(64)) bec_disk_model_i (.ref_clk(ref_clk), .srst(srst), .disk_wr_bit(dwb),
        .disk_wr_en(dwe), .play(play), .err(err), .disk_rd_bit(drb), .disk_rd_valid(drv),
        .surf(surf), .wr_cnt(wr_cnt));
    // ============================================================
    // Clock, watchdog, check and finish helpers
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        complete_run();
    end
    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ============================================================
    // APB master: holds the request until pready is seen at an edge
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge ref_clk);
        {psel, penable, paddr, pwrite, pwdata} <= {2'b10, a, w, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Reference remainder of data times x^32, same generator as the device
    function automatic logic [31:0] rem_of(input logic [31:0] d);
        logic [31:0] r;
        r = 32'h0;
        for (int i = 31; i >= 0; i--) r = {r[30:0], 1'b0} ^ ((d[i] ^ r[31]) ? bec_pkg::GEN_POLY : 32'h0);
        return r;
    endfunction
    task automatic rd_field(input logic [63:0] m, output int cyc);
        rd_q = {};
        err <= m;
        {play, rd_start} <= 2'b11;
        @(posedge ref_clk);
        {play, rd_start} <= 2'b00;
        cyc = 0;
        while (rd_done !== 1'b1) begin
            @(posedge ref_clk);
            cyc++;
        end
    endtask
    // The last word of a field must come with the host blocked, earlier ones not
    always @(posedge ref_clk) if (rd_valid === 1'b1) begin
        rd_q.push_back(rd_data);
        chk("host_block", host_block, rd_q.size() == WORDS);
    end
    // ============================================================
    // Test sequence
    initial begin
        {srst, psel, penable, pwrite, paddr, pwdata, wr_start, wr_valid, wr_data, rd_start, play} = '0;
        srst = 1'b1;
        err = 64'h0;
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
        apb(bec_pkg::OFS_OFFSET, 1'b0, 32'h0); chk("offset_rst", q, 32'h0);
        apb(8'h20, 1'b0, 32'h0); chk("unmapped", {e, q}, 33'h100000000);
        apb(bec_pkg::OFS_OFFSET, 1'b1, 32'hFFFFFFFF);
        apb(bec_pkg::OFS_OFFSET, 1'b0, 32'h0); chk("offset_rw", q, 32'h00001C80);
        apb(bec_pkg::OFS_OFFSET, 1'b1, 32'h00001000);
        // Write one field of two 16-bit words, then look at the recorded surface
        s = {16'hA5C3, 16'h0F0E, rem_of(32'hA5C30F0E)};
        wr_start <= 1'b1;
        @(posedge ref_clk);
        wr_start <= 1'b0;
        wr_valid <= 1'b1;
        for (int w = 0; w < WORDS; w++) begin
            wr_data <= {2'b00, s[63-16*w -: 16]};
            do @(posedge ref_clk); while (wr_ready !== 1'b1);
        end
        wr_valid <= 1'b0;
        while (wr_done !== 1'b1) @(posedge ref_clk);
        // The last check bit lands on the surface at the edge after wr_done
        @(posedge ref_clk);
        chk("wr_bits", wr_cnt, 64);
        chk("surface", surf, s);
        // Clean read, then a correctable burst with correction inhibited and enabled
        rd_field(64'h0, c0);
        chk("rd_words", {rd_q[0], rd_q[1]}, {2'b00, s[63:48], 2'b00, s[47:32]});
        apb(bec_pkg::OFS_ERR1, 1'b0, 32'h0); chk("clean_err1", q, 32'h0);
        apb(bec_pkg::OFS_OFFSET, 1'b1, 32'h00001800);
        rd_field((64'h1 << 58) | (64'h1 << 56), c1);
        chk("inhibit_time", c1, c0);
        apb(bec_pkg::OFS_ERR1, 1'b0, 32'h0); chk("inh_dck", q, 32'h8000);
        apb(bec_pkg::OFS_OFFSET, 1'b1, 32'h00001000);
        rd_field((64'h1 << 58) | (64'h1 << 56), c2);
        chk("iso_longer", c2 > c0, 1);
        apb(bec_pkg::OFS_ERR1, 1'b0, 32'h0); chk("iso_dck", q, 32'h8000);
        apb(bec_pkg::OFS_PATTERN, 1'b0, 32'h0); chk("pattern", q, 32'h5);
        apb(bec_pkg::OFS_POSITION, 1'b0, 32'h0); chk("position", q, 32'h5);
        // Interrupt: masked, enabled, then cleared
        chk("irq_masked", irq, 1'b0);
        apb(bec_pkg::OFS_INT_STAT, 1'b0, 32'h0); chk("int_dck", q & 32'h4, 32'h4);
        apb(bec_pkg::OFS_INT_EN, 1'b1, 32'h4);
        @(posedge ref_clk);
        chk("irq_on", irq, 1'b1);
        apb(bec_pkg::OFS_INT_CLR, 1'b1, 32'h4);
        @(posedge ref_clk);
        chk("irq_off", irq, 1'b0);
        // Two errors far apart: flagged hard, pattern and position left unread
        rd_field((64'h1 << 63) | (64'h1 << 33), c2);
        apb(bec_pkg::OFS_ERR1, 1'b0, 32'h0); chk("hard", q, 32'h8040);
        complete_run();
    end
endmodule
